//--- hdl/vtp_pkg.sv
// Constants for the video test pattern configuration block.
// Assumes a 32-bit AXI4-Lite register bus and a synchronous pixel strobe.
package vtp_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned CNT_W  = 11;

  // Register indices; byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h064;
  localparam logic [IDX_W-1:0] IDX_CFG  = 10'h065;
  localparam logic [IDX_W-1:0] IDX_IA   = 10'h066;
  localparam logic [IDX_W-1:0] IDX_ID   = 10'h067;
  localparam logic [IDX_W-1:0] IDX_DBG  = 10'h068;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h069;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CFG_ASCRL_BIT = 0;
  localparam int unsigned CFG_INV_BIT   = 1;
  localparam int unsigned CFG_TSEL_BIT  = 2;
  localparam int unsigned CFG_EXT_BIT   = 3;
  localparam int unsigned CFG_B18_BIT   = 4;
  localparam int unsigned DBG_BIST_BIT  = 3;
  localparam int unsigned STAT_ERR_BIT  = 7;

  localparam logic [7:0] CTRL_WMASK = 8'h01;
  localparam logic [7:0] CFG_WMASK  = 8'h1f;
  localparam logic [7:0] DBG_WMASK  = 8'h08;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] IA_RST     = 8'h00;
  localparam logic [7:0] DBG_RST    = 8'h00;

  // Indirect map: horizontal and vertical totals and actives are in units of eight.
  localparam int unsigned IND_HTOT  = 0;
  localparam int unsigned IND_HACT  = 1;
  localparam int unsigned IND_HSW   = 2;
  localparam int unsigned IND_HBP   = 3;
  localparam int unsigned IND_VTOT  = 4;
  localparam int unsigned IND_VACT  = 5;
  localparam int unsigned IND_VSW   = 6;
  localparam int unsigned IND_VBP   = 7;
  localparam int unsigned IND_SYNC  = 8;
  localparam int unsigned IND_FTIME = 9;
  localparam int unsigned IND_PMASK = 10;
  localparam int unsigned IND_NSH   = 11;
  localparam logic [7:0]  IND_ERRCNT = 8'h0b;
  localparam logic [7:0]  IND_RST [0:IND_NSH-1] = '{8'h64, 8'h50, 8'h60, 8'h30, 8'h42,
                                                     8'h3c, 8'h02, 8'h21, 8'h00, 8'h3c, 8'hff};

  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [23:0] LOW2_MASK   = 24'h030303;
  localparam int unsigned PIX_DIV     = 2;

  typedef enum logic [2:0] {
    VTP_PASS = 3'b001,
    VTP_GEN  = 3'b010,
    VTP_BIST = 3'b100
  } vtp_mode_t;
endpackage : vtp_pkg

//--- hdl/vtp_mem_if.sv
// Port bundle between the register logic and the indirect register store.
// Assumes a single clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface vtp_mem_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport host (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : vtp_mem_if
`default_nettype wire

//--- hdl/vtp_ind_mem.sv
// Indirect register store with a registered read port.
// Assumes the reader holds the address one cycle before using the data.
`timescale 1ns/10ps
`default_nettype none
module vtp_ind_mem #(
  parameter int unsigned DEPTH = 256
) (
  input  wire logic clk,
  input  wire logic arst_n,
  vtp_mem_if.mem    port
);
  logic [7:0] mem_ff [0:DEPTH-1];
  logic [7:0] rdata_ff;

  // The array has no reset so that it maps onto plain RAM.
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_ff[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= mem_ff[port.raddr];
    end
  end

  assign port.rdata = rdata_ff;
endmodule : vtp_ind_mem
`default_nettype wire

//--- hdl/vtp_top.sv
// Test pattern generator configuration, timing and self-test compare.
// Assumes AXI4-Lite masters and synchronous pixel inputs on clk.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - 18-bit mode: six upper bits, 64 steps.
// - 24-bit mode: 256 brightness steps per color.
// - Clock select picks external or divided pixel clock.
// - Clock select ignored under external timing.
// - Internal timing from programmed frame sizes.
// - External timing follows incoming strobe and syncs.
// - Inversion bit inverts output colors.
// - Auto-scroll advances after programmed frame count.
// - Without auto-scroll the pattern holds.
// - Eight-bit indirect address register.
// - Indirect data write reaches addressed register.
// - Indirect data read returns addressed register.
// - Self-test compares received video to pattern.
// - Enable bit switches generator on and off.
// - Self-test error flag when count nonzero.
module vtp_top import vtp_pkg::*; (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_pclk_en,
  input  wire logic              in_de,
  input  wire logic              in_hs,
  input  wire logic              in_vs,
  input  wire logic [23:0]       in_rgb,
  output logic                   out_pclk_en,
  output logic                   out_de,
  output logic                   out_hs,
  output logic                   out_vs,
  output logic [23:0]            out_rgb
);
  vtp_mem_if mem_if ();
  vtp_ind_mem u_mem (.clk(clk), .arst_n(arst_n), .port(mem_if.mem));

  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [7:0]  ctrl_ff, cfg_ff, ia_ff, dbg_ff, err_ff, ftcnt_ff;
  logic [7:0]  sh_ff [0:IND_NSH-1];
  logic [4:0]  act_ff;
  vtp_mode_t   mode_ff, nxt_mode;
  logic [2:0]  pat_ff;
  logic [7:0]  div_ff;
  logic [CNT_W-1:0] h_ff, v_ff, ex_ff, ey_ff;
  logic        de_q_ff, vs_q_ff;

  // Write path: address and data may arrive in either order.
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  wire wr_go = aw_hold_ff && w_hold_ff;
  wire [IDX_W-1:0] wr_idx = awaddr_ff[ADDR_W-1:2];
  wire wr_al = (awaddr_ff[1:0] == 2'b00);
  wire wr_map = wr_al && (wr_idx inside {IDX_CTRL, IDX_CFG, IDX_IA, IDX_ID, IDX_DBG, IDX_STAT});
  wire wr_b0 = wr_go && wr_map && wstrb_ff[0];
  wire [7:0] wb = wdata_ff[7:0];
  wire wr_ctrl = wr_b0 && (wr_idx == IDX_CTRL);
  wire wr_cfg  = wr_b0 && (wr_idx == IDX_CFG);
  wire wr_ia   = wr_b0 && (wr_idx == IDX_IA);
  wire wr_id   = wr_b0 && (wr_idx == IDX_ID);
  wire wr_dbg  = wr_b0 && (wr_idx == IDX_DBG);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Direct registers; reserved bits are masked off on every write.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= CTRL_RST;
      cfg_ff  <= CFG_RST;
      ia_ff   <= IA_RST;
      dbg_ff  <= DBG_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= wb & CTRL_WMASK;
      if (wr_cfg)  cfg_ff  <= wb & CFG_WMASK;
      if (wr_ia)   ia_ff   <= wb;
      if (wr_dbg)  dbg_ff  <= wb & DBG_WMASK;
    end
  end

  // Timing, frame time and pattern mask are mirrored in flops so the
  // generator never competes with software for the single read port.
  genvar gi;
  generate
    for (gi = 0; gi < IND_NSH; gi++) begin : g_sh
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) sh_ff[gi] <= IND_RST[gi];
        else if (wr_id && ia_ff == 8'(gi)) sh_ff[gi] <= wb;
      end
    end
  endgenerate
  assign mem_if.we    = wr_id;
  assign mem_if.waddr = ia_ff;
  assign mem_if.wdata = wb;
  assign mem_if.raddr = ia_ff;
  wire [7:0] ind_rd = (ia_ff < 8'(IND_NSH)) ? sh_ff[ia_ff[3:0]] :
                      (ia_ff == IND_ERRCNT) ? err_ff : mem_if.rdata;

  // Read path: one cycle from address to data.
  assign s_axi_arready = !rvalid_ff;
  wire [IDX_W-1:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire rd_al = (s_axi_araddr[1:0] == 2'b00);
  wire [7:0] stat_rd = {(err_ff != 8'h00), 7'h00};
  wire [8:0] rd_sel = !rd_al ? 9'h100 :
                      (rd_idx == IDX_CTRL) ? {1'b0, ctrl_ff} :
                      (rd_idx == IDX_CFG)  ? {1'b0, cfg_ff} :
                      (rd_idx == IDX_IA)   ? {1'b0, ia_ff} :
                      (rd_idx == IDX_ID)   ? {1'b0, ind_rd} :
                      (rd_idx == IDX_DBG)  ? {1'b0, dbg_ff} :
                      (rd_idx == IDX_STAT) ? {1'b0, stat_rd} : 9'h100;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h0, rd_sel[7:0]};
      rresp_ff  <= rd_sel[8] ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // Active settings, taken over at a frame boundary, or at once while in pass-through or disabled.
  wire tsel_act  = act_ff[CFG_TSEL_BIT];
  wire ext_act   = act_ff[CFG_EXT_BIT] && tsel_act;
  wire inv_act   = act_ff[CFG_INV_BIT];
  wire b18_act   = act_ff[CFG_B18_BIT];
  wire ascrl_act = act_ff[CFG_ASCRL_BIT];
  wire int_pix   = (div_ff == 8'h00);
  wire pix_en    = (tsel_act && !ext_act) ? int_pix : ext_pclk_en;

  wire [CNT_W-1:0] htot = {sh_ff[IND_HTOT], 3'b000};
  wire [CNT_W-1:0] vtot = {sh_ff[IND_VTOT], 3'b000};
  wire [CNT_W-1:0] hofs = CNT_W'(sh_ff[IND_HSW]) + CNT_W'(sh_ff[IND_HBP]);
  wire [CNT_W-1:0] vofs = CNT_W'(sh_ff[IND_VSW]) + CNT_W'(sh_ff[IND_VBP]);
  wire [CNT_W-1:0] hend = hofs + {sh_ff[IND_HACT], 3'b000};
  wire [CNT_W-1:0] vend = vofs + {sh_ff[IND_VACT], 3'b000};
  wire h_last  = (h_ff >= htot - CNT_W'(1));
  wire v_last  = (v_ff >= vtot - CNT_W'(1));
  wire int_hs  = (h_ff < CNT_W'(sh_ff[IND_HSW])) ^ sh_ff[IND_SYNC][0];
  wire int_vs  = (v_ff < CNT_W'(sh_ff[IND_VSW])) ^ sh_ff[IND_SYNC][1];
  wire int_de  = (h_ff >= hofs) && (h_ff < hend) && (v_ff >= vofs) && (v_ff < vend);
  wire vid_de  = tsel_act ? int_de : in_de;
  wire vid_hs  = tsel_act ? int_hs : in_hs;
  wire vid_vs  = tsel_act ? int_vs : in_vs;
  wire [CNT_W-1:0] pos_x = tsel_act ? h_ff - hofs : ex_ff;
  wire [CNT_W-1:0] pos_y = tsel_act ? v_ff - vofs : ey_ff;
  wire frame_start = tsel_act ? (pix_en && h_last && v_last) : (in_vs && !vs_q_ff);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff  <= 8'h00;
      h_ff    <= '0;
      v_ff    <= '0;
      ex_ff   <= '0;
      ey_ff   <= '0;
      de_q_ff <= 1'b0;
      vs_q_ff <= 1'b0;
    end else begin
      div_ff  <= int_pix ? 8'(PIX_DIV - 1) : div_ff - 8'h01;
      vs_q_ff <= in_vs;
      if (pix_en) begin
        h_ff    <= h_last ? '0 : h_ff + CNT_W'(1);
        if (h_last) v_ff <= v_last ? '0 : v_ff + CNT_W'(1);
        de_q_ff <= in_de;
        ex_ff   <= in_de ? ex_ff + CNT_W'(1) : '0;
        if (!in_de && de_q_ff) ey_ff <= ey_ff + CNT_W'(1);
      end
      if (in_vs && !vs_q_ff) ey_ff <= '0;
    end
  end

  // Settings and mode change together so no frame is torn.
  assign nxt_mode = !ctrl_ff[CTRL_EN_BIT] ? VTP_PASS :
                    dbg_ff[DBG_BIST_BIT] ? VTP_BIST : VTP_GEN;
  // Switching off is immediate, and a disabled generator applies no setting.
  wire take_cfg = frame_start || (mode_ff == VTP_PASS) || !ctrl_ff[CTRL_EN_BIT];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_ff  <= CFG_RST[4:0];
      mode_ff <= VTP_PASS;
    end else if (take_cfg) begin
      act_ff  <= (nxt_mode == VTP_PASS) ? 5'h00 : cfg_ff[4:0];
      mode_ff <= nxt_mode;
    end
  end

  function automatic logic [2:0] next_pat(input logic [2:0] cur, input logic [7:0] msk);
    logic [2:0] c;
    logic [2:0] r;
    r = cur;
    for (int i = 7; i >= 1; i--) begin
      c = cur + 3'(i);
      if (msk[c]) r = c;
    end
    return r;
  endfunction : next_pat

  wire scroll_due = ({1'b0, ftcnt_ff} + 9'h001) >= {1'b0, sh_ff[IND_FTIME]};
  wire scroll_go  = frame_start && ascrl_act && (mode_ff != VTP_PASS);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ftcnt_ff <= 8'h00;
      pat_ff   <= 3'h0;
    end else if (!ascrl_act) begin
      ftcnt_ff <= 8'h00;
    end else if (scroll_go) begin
      ftcnt_ff <= scroll_due ? 8'h00 : ftcnt_ff + 8'h01;
      if (scroll_due) pat_ff <= next_pat(pat_ff, sh_ff[IND_PMASK]);
    end
  end

  // Patterns: white, black, red, green, blue, grey ramps and a red ramp.
  wire [7:0] rx = pos_x[7:0];
  wire [7:0] ry = pos_y[7:0];
  logic [23:0] raw_rgb;
  always_comb begin
    unique case (pat_ff)
      3'h0: raw_rgb = 24'hffffff;
      3'h1: raw_rgb = 24'h000000;
      3'h2: raw_rgb = 24'hff0000;
      3'h3: raw_rgb = 24'h00ff00;
      3'h4: raw_rgb = 24'h0000ff;
      3'h5: raw_rgb = {rx, rx, rx};
      3'h6: raw_rgb = {ry, ry, ry};
      3'h7: raw_rgb = {rx, 16'h0000};
    endcase
  end
  // Clearing the two low bits after inversion leaves 64 steps in 18-bit mode.
  wire [23:0] inv_rgb = inv_act ? ~raw_rgb : raw_rgb;
  wire [23:0] gen_rgb = b18_act ? (inv_rgb & ~LOW2_MASK) : inv_rgb;
  wire mism = (mode_ff == VTP_BIST) && pix_en && in_de && vid_de && (in_rgb != gen_rgb);

  // A mismatch in the clearing cycle still counts, so no error is lost.
  wire err_clr = wr_dbg && wb[DBG_BIST_BIT] && !dbg_ff[DBG_BIST_BIT];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) err_ff <= 8'h00;
    else if (err_clr) err_ff <= mism ? 8'h01 : 8'h00;
    else if (mism && err_ff != 8'hff) err_ff <= err_ff + 8'h01;
  end

  logic        o_de, o_hs, o_vs;
  logic [23:0] o_rgb;
  always_comb begin
    unique case (mode_ff)
      VTP_GEN: begin
        o_de  = vid_de;
        o_hs  = vid_hs;
        o_vs  = vid_vs;
        o_rgb = vid_de ? gen_rgb : 24'h000000;
      end
      default: begin
        o_de  = in_de;
        o_hs  = in_hs;
        o_vs  = in_vs;
        o_rgb = in_rgb;
      end
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_de  <= 1'b0;
      out_hs  <= 1'b0;
      out_vs  <= 1'b0;
      out_rgb <= 24'h000000;
    end else if (pix_en) begin
      out_de  <= o_de;
      out_hs  <= o_hs;
      out_vs  <= o_vs;
      out_rgb <= o_rgb;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) out_pclk_en <= 1'b0;
    else out_pclk_en <= pix_en;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_cfg_reserved: assert property ((cfg_ff & ~CFG_WMASK) == 8'h00 && (dbg_ff & ~DBG_WMASK) == 8'h00)
    else $error("reserved config bits set");
  a_depth_18: assert property (b18_act |-> (gen_rgb & LOW2_MASK) == 24'h0)
    else $error("18-bit pattern uses low bits");
  a_depth_24: assert property (!b18_act && !inv_act |-> gen_rgb == raw_rgb)
    else $error("24-bit pattern altered");
  a_color_inv: assert property (pix_en && mode_ff == VTP_GEN && vid_de && inv_act && !b18_act
                                |=> out_rgb == ~$past(raw_rgb))
    else $error("inverted color not driven");
  a_clock_src: assert property (tsel_act |-> pix_en == (act_ff[CFG_EXT_BIT] ? ext_pclk_en : int_pix))
    else $error("pixel clock source wrong");
  a_ext_clock: assert property (!tsel_act |-> pix_en == ext_pclk_en)
    else $error("clock select not ignored");
  a_int_timing: assert property (pix_en && mode_ff == VTP_GEN && tsel_act
                                 |=> out_hs == $past(int_hs) && out_de == $past(int_de))
    else $error("internal timing not driven");
  a_ext_timing: assert property (pix_en && mode_ff == VTP_GEN && !tsel_act
                                 |=> out_de == $past(in_de) && out_vs == $past(in_vs))
    else $error("external timing not followed");
  a_scroll_step: assert property (scroll_go && scroll_due |=> ftcnt_ff == 8'h00)
    else $error("scroll did not restart count");
  a_scroll_hold: assert property (!ascrl_act |=> $stable(pat_ff))
    else $error("pattern moved without scroll");
  a_ia_write: assert property (wr_ia |=> ia_ff == $past(wb))
    else $error("indirect address not stored");
  a_ind_write: assert property (wr_id |-> mem_if.we && mem_if.waddr == ia_ff)
    else $error("indirect write misdirected");
  a_ind_read: assert property (s_axi_arvalid && s_axi_arready && rd_al && rd_idx == IDX_ID
                               |=> rdata_ff[7:0] == $past(ind_rd))
    else $error("indirect read wrong");
  a_bist_pass: assert property (pix_en && mode_ff == VTP_BIST |=> out_rgb == $past(in_rgb))
    else $error("self-test drives pattern");
  a_gen_off: assert property (!ctrl_ff[CTRL_EN_BIT] |=> mode_ff == VTP_PASS)
    else $error("generator not switched off");
  a_err_flag: assert property (mism && !err_clr |=> err_ff != 8'h00 ##0 stat_rd[STAT_ERR_BIT])
    else $error("self-test error not flagged");
  a_frame_cfg: assert property (!take_cfg |=> $stable(act_ff) && $stable(mode_ff))
    else $error("settings changed mid frame");
  c_scroll: cover property (scroll_go && scroll_due);
  c_bist_err: cover property (mism);
  c_ind_read: cover property (s_axi_arvalid && s_axi_arready && rd_idx == IDX_ID);
endmodule : vtp_top
`default_nettype wire

//--- tb/vtp_video_src.sv
// Upstream video source model: small frames, one pixel every second clock.
// Assumes it shares clk and arst_n with the block under test.
`timescale 1ns/10ps
`default_nettype none
module vtp_video_src (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        white,
  input  wire logic        corrupt,
  output logic             pclk_en,
  output logic             de,
  output logic             hs,
  output logic             vs,
  output logic [23:0]      rgb
);
  logic [3:0] h_ff;
  logic [3:0] v_ff;
  wire        act = (h_ff < 4'hc) && (v_ff < 4'h8);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {pclk_en, de, hs, vs, h_ff, v_ff} <= '0;
      rgb <= '0;
    end else begin
      pclk_en <= ~pclk_en;
      if (!pclk_en) begin
        de <= act;
        hs <= h_ff == 4'he;
        vs <= v_ff == 4'h9;
        // Blanking data changes every pixel so a stale value is never mistaken for a match.
        rgb <= (white && act) ? (corrupt ? 24'hff00ff : 24'hffffff) : {3{h_ff, v_ff}};
        h_ff <= h_ff + 4'h1;
        if (h_ff == 4'hf) v_ff <= (v_ff == 4'h9) ? 4'h0 : v_ff + 4'h1;
      end
    end
  end
endmodule : vtp_video_src
`default_nettype wire

//--- tb/vtp_top_tb.sv
// Self-checking bench: register bus traffic, video pass, pattern and self-test.
// Assumes the video source model drives the received video side.
`timescale 1ns/10ps
`default_nettype none
module vtp_top_tb import vtp_pkg::*; ;
  logic              clk, arst_n, white, corrupt, s_axi_bready, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, seed, x;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, ext_pclk_en, in_de, in_hs;
  logic              in_vs, out_pclk_en, out_de, out_hs, out_vs;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [23:0]       in_rgb, out_rgb, vexp;
  logic [7:0]        ia;
  logic [33:0]       e;
  int                mismatches, checks_done, vmode, pcnt, wcnt;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [26:0]       vq[$];
  vtp_top DUT (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_pclk_en, .in_de, .in_hs, .in_vs, .in_rgb, .out_pclk_en, .out_de,
    .out_hs, .out_vs, .out_rgb);
  vtp_video_src SRC (.clk, .arst_n, .white, .corrupt, .pclk_en(ext_pclk_en), .de(in_de),
    .hs(in_hs), .vs(in_vs), .rgb(in_rgb));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [11:0] ra(logic [9:0] i);
    return {i, 2'b00};
  endfunction : ra
  task automatic check(string n, logic [31:0] s, logic [31:0] v);
    checks_done++;
    if (s !== v) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, v, s);
    end
  endtask : check
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er = RESP_OKAY);
    logic aw;
    logic w;
    bq.push_back(er);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
    {aw, w} = 2'b11;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] v, logic [1:0] er = RESP_OKAY);
    rq.push_back({er, v});
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask : rd
  task automatic vid(int m, int n);
    vq.delete();
    vmode = m;
    repeat (n) @(posedge clk);
    vmode = 0;
  endtask : vid
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      check("rdata", s_axi_rdata, e[31:0]);
      check("rresp", 32'(s_axi_rresp), 32'(e[33:32]));
    end
  end
  always @(negedge clk) begin
    if (vmode == 1 && out_pclk_en && vq.size() > 0)
      check("pass_vid", 32'({out_de,out_hs,out_vs,out_rgb}), 32'(vq.pop_front()));
    if (vmode == 1 && ext_pclk_en) vq.push_back({in_de, in_hs, in_vs, in_rgb});
    if (vmode == 4 && out_de && out_rgb == 24'h0) pcnt++;
    if (vmode == 4 && out_de && out_rgb == 24'hffffff) wcnt++;
    if (vmode == 2 && out_de) check("gen_rgb", 32'(out_rgb), 32'(vexp));
    if (vmode == 3 && out_pclk_en) pcnt++;
  end
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    {arst_n, white, corrupt, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {seed, s_axi_wstrb, vmode, vexp} = {32'h20ed, 4'hf, 32'h0, 24'h0};
    repeat (2) @(posedge clk);
    arst_n <= 1;
    rd(ra(IDX_CTRL), 0);
    rd(ra(IDX_CFG), 0);
    rd(ra(IDX_DBG), 0);
    rd(ra(IDX_STAT), 0);
    rd(ra(IDX_IA), 0);
    for (int i = 0; i < IND_NSH; i++) begin
      wr(ra(IDX_IA), i);
      rd(ra(IDX_ID), IND_RST[i]);
    end
    repeat (4) begin
      x = rnd();
      ia = 8'h0c + 8'(x % 244);
      wr(ra(IDX_IA), {x[31:8], ia});
      x = rnd();
      wr(ra(IDX_ID), x);
      rd(ra(IDX_IA), ia);
      rd(ra(IDX_ID), x[7:0]);
    end
    wr(ra(IDX_CFG), 32'hff);
    rd(ra(IDX_CFG), CFG_WMASK);
    s_axi_wstrb <= 4'he;
    wr(ra(IDX_CFG), 0);
    s_axi_wstrb <= 4'hf;
    rd(ra(IDX_CFG), CFG_WMASK);
    wr(ra(IDX_DBG), 32'hf7);
    rd(ra(IDX_DBG), 0);
    wr(ra(IDX_STAT), 32'hff);
    rd(ra(IDX_STAT), 0);
    wr(12'h1c0, 1, RESP_SLVERR);
    rd(12'h1c0, 0, RESP_SLVERR);
    rd(12'h195, 0, RESP_SLVERR);
    wr(ra(IDX_CFG), 0);
    vid(1, 400);
    // Back-channel transmitter lives outside this block, so nothing to power down.
    wr(ra(IDX_CTRL), 1);
    // Settings only land at a frame start, so each case waits out two source frames.
    for (int i = 0; i < 3; i++) begin
      wr(ra(IDX_CFG), i == 0 ? 8'h08 : i == 1 ? 8'h0a : 8'h10);
      repeat (700) @(posedge clk);
      vexp = i == 0 ? 24'hffffff : i == 1 ? 24'h0 : 24'hffffff & ~LOW2_MASK;
      vid(2, 400);
    end
    wr(ra(IDX_CFG), 0);
    white <= 1;
    wr(ra(IDX_DBG), 8);
    repeat (700) @(posedge clk);
    vid(1, 400);
    rd(ra(IDX_STAT), 0);
    corrupt <= 1;
    repeat (400) @(posedge clk);
    corrupt <= 0;
    rd(ra(IDX_STAT), 32'h80);
    wr(ra(IDX_DBG), 0);
    // Two patterns, one frame each, so the output must show both white and black.
    wr(ra(IDX_IA), IND_FTIME);
    wr(ra(IDX_ID), 1);
    wr(ra(IDX_IA), IND_PMASK);
    wr(ra(IDX_ID), 3);
    wr(ra(IDX_CFG), 1);
    repeat (700) @(posedge clk);
    {pcnt, wcnt} = '0;
    vid(4, 700);
    check("scroll", 32'(pcnt > 0 && wcnt > 0), 1);
    wr(ra(IDX_CFG), 4);
    repeat (700) @(posedge clk);
    pcnt = 0;
    vid(3, 200);
    check("pix_div", pcnt, 200 / PIX_DIV);
    wr(ra(IDX_CTRL), 0);
    vid(1, 400);
    finish_test();
  end
endmodule : vtp_top_tb
`default_nettype wire
